// File: verilog/psr_pkg.sv
// Purpose: Shared constants for the strap and reset configuration block
// Assumes: APB slave with 32-bit data, 50 MHz pclk
// Notes:   Offsets are byte addresses, one aligned word per register
package psr_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] PSR_OFF_CTRL = 8'h00; // Control, soft reset
	localparam logic [7:0] PSR_OFF_CFG  = 8'h10; // Media and sleep config
	localparam logic [7:0] PSR_OFF_STAT = 8'h14; // Live block state

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int PSR_BIT_SRST  = 15; // Control: software reset
	localparam int PSR_BIT_MEDIA = 0;  // Config: 1 = fiber
	localparam int PSR_BIT_PAUSE = 2;  // Config: advertise pause
	localparam int PSR_BIT_SLEEP = 6;  // Config: sleep enable
	localparam int PSR_ST_BUSY   = 0;  // Status: reset cycle running
	localparam int PSR_ST_MEDIA  = 1;  // Status: fiber selected
	localparam int PSR_ST_MDIS   = 2;  // Status: management disabled
	localparam int PSR_ST_SLEEP  = 3;  // Status: sleep enable in force
	localparam int PSR_ST_PAUSE  = 4;  // Status: pause advertised
	localparam int PSR_ST_ADDR   = 8;  // Status: device address, 5 bits
	localparam int PSR_ADDR_W    = 5;  // Device address width

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int PSR_CLK_NS     = 20;     // pclk period
	localparam int PSR_RST_EXT_NS = 258000; // Reset stretch, 258 us
	localparam int PSR_RST_CYC    = PSR_RST_EXT_NS / PSR_CLK_NS;
	localparam int PSR_CNT_W      = 16;     // Stretch counter width

	// ----------------------------------------
	// Reset sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		PSR_RUN     = 2'b00, // Normal operation
		PSR_HOLD    = 2'b01, // Reset pin held low
		PSR_STRETCH = 2'b10  // Counting out the extension
	} psr_state_t;

endpackage

// File: verilog/psr_core.sv
// Purpose: Strap sampling, reset combining and sleep control with APB registers
// Assumes: Pins synchronous to pclk; APB answers with no wait state
// Notes:   Register offsets and fields live in the package
// Overview of operation
// [R01] Media strap sampled in reset sets bit
// [R02] Fiber mode reuses media pin as detect
// [R03] Board holds media pin low for copper
// [R04] Device address taken from address pins
// [R05] Reset pin or soft bit resets device
// [R06] Reset stretched 258 us after release
// [R07] Pause strap high advertises pause
// [R08] Sleep pin high allows sleep mode
// [R09] Managed mode: register bit overrides sleep pin
// [R10] Managed: straps give defaults, then registers
// [R11] Management disabled: register accesses ignored
// [R12] Straps latched at end of reset cycle
// [R13] Soft reset bit self-clears at end
`timescale 1ns/10ps
module psr_core import psr_pkg::*; #(
	parameter int RST_CYCLES = PSR_RST_CYC // Stretch length in pclk cycles
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  hw_reset_n,
	input  wire logic                  media_sel_sigdet_pin,
	input  wire logic [PSR_ADDR_W-1:0] dev_addr_pins,
	input  wire logic                  mgmt_disable_strap,
	input  wire logic                  pause_strap,
	input  wire logic                  sleep_pin,
	output logic                       reset_busy,
	output logic                       media_fiber,
	output logic                       fiber_signal_detect,
	output logic [PSR_ADDR_W-1:0]      dev_addr,
	output logic                       pause_adv,
	output logic                       sleep_en
);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	localparam logic [PSR_CNT_W-1:0] CNT_TOP = PSR_CNT_W'(RST_CYCLES - 1); // Reload value

	psr_state_t           state_q, state_d;   // Reset sequencer
	logic [PSR_CNT_W-1:0] cnt_q, cnt_d;       // Stretch countdown
	logic                 srst_q, srst_d;     // Soft reset bit
	logic                 media_q, media_d;   // Media select
	logic                 mdis_q, mdis_d;     // Management disabled
	logic                 pause_q, pause_d;   // Pause default / value
	logic                 sleep_q, sleep_d;   // Sleep register bit
	logic                 busy_q, busy_d;     // Reset cycle running
	logic                 sd_q, sd_d;         // Signal detect out
	logic [PSR_ADDR_W-1:0] addr_q, addr_d;    // Device address
	logic                 padv_q, padv_d;     // Pause advertised
	logic                 slen_q, slen_d;     // Sleep enable in force
	logic [31:0]          rdata_q, rdata_d;   // Read data
	logic                 err_q, err_d;       // Error answer
	logic                 setup;              // APB setup phase
	logic                 access;             // Register access allowed
	logic                 wr_ctrl;            // Write to control
	logic                 wr_cfg;             // Write to config
	logic                 soft_go;            // Soft reset request
	logic                 stretch_end;        // Last stretch cycle
	logic                 mapped;             // Address hits a register

	// Zero wait state: data was prepared in the setup cycle
	assign pready  = 1'b1;
	assign prdata  = rdata_q;
	assign pslverr = err_q;
	assign setup   = psel & ~penable;
	assign mapped  = (paddr == PSR_OFF_CTRL) | (paddr == PSR_OFF_CFG) | (paddr == PSR_OFF_STAT);

	// Accesses do nothing while strapped off or mid-reset
	assign access  = ~mdis_q & ~busy_q; // R11
	assign wr_ctrl = psel & penable & pwrite & access & (paddr == PSR_OFF_CTRL);
	assign wr_cfg  = psel & penable & pwrite & access & (paddr == PSR_OFF_CFG);
	assign soft_go = wr_ctrl & pwdata[PSR_BIT_SRST]; // R05
	assign stretch_end = (state_q == PSR_STRETCH) & (cnt_q == '0) & hw_reset_n;

	// ----------------------------------------
	// Reset sequencer
	// ----------------------------------------
	// Next state: pin low holds, release starts the stretch
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			PSR_RUN: begin
				if (!hw_reset_n) begin // R05
					state_d = PSR_HOLD;
				end else if (soft_go) begin // R05
					state_d = PSR_STRETCH;
					cnt_d   = CNT_TOP;
				end
			end
			PSR_HOLD: begin
				// Count starts only after the pin is released
				if (hw_reset_n) begin // R06
					state_d = PSR_STRETCH;
					cnt_d   = CNT_TOP;
				end
			end
			PSR_STRETCH: begin
				if (!hw_reset_n) begin // R05
					state_d = PSR_HOLD;
				end else if (cnt_q == '0) begin // R06
					state_d = PSR_RUN;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			default: begin
				state_d = PSR_HOLD;
			end
		endcase
	end

	// Power-up runs a full stretch too, so straps get sampled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= PSR_STRETCH;
			cnt_q   <= CNT_TOP;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// ----------------------------------------
	// Configuration state
	// ----------------------------------------
	// Straps track the pins through reset; last sample sticks
	always_comb begin
		srst_d  = srst_q;
		media_d = media_q;
		mdis_d  = mdis_q;
		pause_d = pause_q;
		sleep_d = sleep_q;
		if (soft_go) begin
			srst_d = 1'b1;
		end else if (stretch_end) begin
			srst_d = 1'b0; // R13
		end
		if (state_q != PSR_RUN) begin
			media_d = media_sel_sigdet_pin; // R01 R12
			mdis_d  = mgmt_disable_strap;   // R12
			pause_d = pause_strap;          // R10
			sleep_d = sleep_pin;            // R10
		end else if (wr_cfg) begin
			// Managed mode: software owns the bits after reset
			media_d = pwdata[PSR_BIT_MEDIA]; // R10
			pause_d = pwdata[PSR_BIT_PAUSE]; // R10
			sleep_d = pwdata[PSR_BIT_SLEEP]; // R09
		end
	end

	// Defaults are neutral until the first strap sample
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			srst_q  <= 1'b0;
			media_q <= 1'b0;
			mdis_q  <= 1'b0;
			pause_q <= 1'b0;
			sleep_q <= 1'b0;
		end else begin
			srst_q  <= srst_d;
			media_q <= media_d;
			mdis_q  <= mdis_d;
			pause_q <= pause_d;
			sleep_q <= sleep_d;
		end
	end

	// ----------------------------------------
	// Pin-facing outputs
	// ----------------------------------------
	// Detect is masked in copper mode, where the pin is tied low
	always_comb begin
		busy_d = (state_d != PSR_RUN);
		sd_d   = media_q & ~busy_d & media_sel_sigdet_pin; // R02
		addr_d = dev_addr_pins;                            // R04
		// Strapped-off mode follows pins live, managed uses registers
		padv_d = mdis_q ? pause_strap : pause_q;           // R07
		slen_d = mdis_q ? sleep_pin : sleep_q;             // R08 R09
	end

	// All pin outputs registered to keep them glitch free
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b1;
			sd_q   <= 1'b0;
			addr_q <= '0;
			padv_q <= 1'b0;
			slen_q <= 1'b0;
		end else begin
			busy_q <= busy_d;
			sd_q   <= sd_d;
			addr_q <= addr_d;
			padv_q <= padv_d;
			slen_q <= slen_d;
		end
	end

	assign reset_busy          = busy_q;
	assign media_fiber         = media_q;
	assign fiber_signal_detect = sd_q;
	assign dev_addr            = addr_q;
	assign pause_adv           = padv_q;
	assign sleep_en            = slen_q;

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Read data built in setup so access can finish at once
	always_comb begin
		rdata_d = rdata_q;
		err_d   = err_q;
		if (setup) begin
			rdata_d = 32'h0000_0000;
			err_d   = ~mapped;
			if (access) begin // R11
				case (paddr)
					PSR_OFF_CTRL: rdata_d[PSR_BIT_SRST] = srst_q;
					PSR_OFF_CFG: begin
						rdata_d[PSR_BIT_MEDIA] = media_q;
						rdata_d[PSR_BIT_PAUSE] = pause_q;
						rdata_d[PSR_BIT_SLEEP] = sleep_q;
					end
					PSR_OFF_STAT: begin
						rdata_d[PSR_ST_BUSY]  = busy_q;
						rdata_d[PSR_ST_MEDIA] = media_q;
						rdata_d[PSR_ST_MDIS]  = mdis_q;
						rdata_d[PSR_ST_SLEEP] = slen_q;
						rdata_d[PSR_ST_PAUSE] = padv_q;
						rdata_d[PSR_ST_ADDR +: PSR_ADDR_W] = addr_q;
					end
					default: rdata_d = 32'h0000_0000;
				endcase
			end
		end
	end

	// Read data register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 32'h0000_0000;
			err_q   <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			err_q   <= err_d;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [PSR_CNT_W-1:0] seen_q; // Cycles spent in stretch

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_q <= '0;
		end else begin
			seen_q <= (state_q == PSR_STRETCH && state_d == PSR_STRETCH) ? seen_q + 1'b1 : '0;
		end
	end

	media_strap_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
		stretch_end |=> media_fiber == $past(media_sel_sigdet_pin))
		else $error("media strap not latched at reset end");
	sigdet_mask_a: assert property (@(posedge pclk) disable iff (!presetn) // R02
		(!media_q || busy_d) |=> !fiber_signal_detect)
		else $error("signal detect seen outside fiber run");
	addr_follow_a: assert property (@(posedge pclk) disable iff (!presetn) // R04
		presetn |=> dev_addr == $past(dev_addr_pins))
		else $error("device address does not follow pins");
	pin_reset_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
		!hw_reset_n |=> reset_busy [*2])
		else $error("reset pin did not reset");
	soft_reset_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
		soft_go |=> reset_busy && srst_q)
		else $error("soft reset bit did not reset");
	stretch_len_a: assert property (@(posedge pclk) disable iff (!presetn) // R06
		(stretch_end && $past(state_q) == PSR_STRETCH) |-> seen_q == CNT_TOP)
		else $error("reset stretch length wrong");
	pause_pin_a: assert property (@(posedge pclk) disable iff (!presetn) // R07
		mdis_q |=> pause_adv == $past(pause_strap))
		else $error("pause advertisement not following strap");
	sleep_sel_a: assert property (@(posedge pclk) disable iff (!presetn) // R08 R09
		presetn |=> sleep_en == ($past(mdis_q) ? $past(sleep_pin) : $past(sleep_q)))
		else $error("sleep enable from wrong source");
	cfg_write_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
		(wr_cfg && state_q == PSR_RUN && hw_reset_n) |=> sleep_q == $past(pwdata[PSR_BIT_SLEEP]))
		else $error("managed config write lost");
	mgmt_ignore_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
		(mdis_q && state_q == PSR_RUN && hw_reset_n) |=> $stable(sleep_q) && $stable(media_q))
		else $error("access not ignored while disabled");
	srst_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
		stretch_end |=> !srst_q && !reset_busy)
		else $error("soft reset bit not cleared");

endmodule // psr_core

// File: tb/psr_board_model.sv
// Purpose: Board strap and fiber module model on the media pin
// Assumes: Bench sets the board levels at clock edges
// Notes:   Other straps are plain levels driven by the bench
`timescale 1ns/10ps
module psr_board_model (
	input  wire logic fiber_mode,          // Board built for fiber
	input  wire logic sig_level,           // Optical module detect level
	input  wire logic reset_busy,          // Device reset cycle running
	output logic      media_sel_sigdet_pin // Shared strap and detect pin
);
	// ----------------------------------------
	// Media pin
	// ----------------------------------------
	// Strap high in reset, module detect after; copper ties it to ground
	always_comb begin
		if (!fiber_mode) begin
			media_sel_sigdet_pin = 1'b0;
		end else begin
			media_sel_sigdet_pin = reset_busy ? 1'b1 : sig_level;
		end
	end
endmodule // psr_board_model

// File: tb/phy_strap_reset_config_tb.sv
// Purpose: Self-checking bench for the strap and reset block
// Assumes: Short reset stretch so the run stays brief
// Notes:   APB stands in for the management channel
`timescale 1ns/10ps
module phy_strap_reset_config_tb import psr_pkg::*;;
	localparam int RST = 20; // Shortened stretch
	logic pclk, presetn, psel, penable, pwrite, hw_reset_n, media_sel_sigdet_pin;
	logic mgmt_disable_strap, pause_strap, sleep_pin, pready, pslverr, fiber, sig;
	logic reset_busy, media_fiber, fiber_signal_detect, pause_adv, sleep_en, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic [4:0]  dev_addr_pins, dev_addr;
	int          miscompares, check_count, n;

	psr_core #(.RST_CYCLES(RST)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .hw_reset_n(hw_reset_n),
		.media_sel_sigdet_pin(media_sel_sigdet_pin), .dev_addr_pins(dev_addr_pins),
		.mgmt_disable_strap(mgmt_disable_strap), .pause_strap(pause_strap), .sleep_pin(sleep_pin),
		.reset_busy(reset_busy), .media_fiber(media_fiber), .fiber_signal_detect(fiber_signal_detect),
		.dev_addr(dev_addr), .pause_adv(pause_adv), .sleep_en(sleep_en));
	psr_board_model board_u (.fiber_mode(fiber), .sig_level(sig), .reset_busy(reset_busy),
		.media_sel_sigdet_pin(media_sel_sigdet_pin));

	// ----------------------------------------
	// Clock and tasks
	// ----------------------------------------
	always #10 pclk = ~pclk;

	// One APB transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Bounded wait for the reset cycle to end, n counts edges
	task automatic wait_idle();
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (reset_busy !== 1'b0 && n < 100);
		// A stuck reset cycle counts as a mismatch here
		chk(reset_busy, 32'h0);
	endtask

	task automatic settle();
		repeat (2) @(posedge pclk);
		#1;
	endtask

	task automatic results();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Watchdog at 5000 cycles, well past the couple hundred cycles of the tests
	initial begin
		#100000;
		miscompares++;
		$display("mismatch at %0t: watchdog expired", $time);
		results();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{pclk, psel, penable, pwrite, presetn, fiber, sig, mgmt_disable_strap} = '0;
		{paddr, pwdata} = '0;
		{hw_reset_n, pause_strap, sleep_pin} = 3'h7;
		dev_addr_pins = 5'h0A;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		wait_idle();
		chk(media_fiber, 0);
		chk(pause_adv, 1);
		chk(dev_addr, 5'h0A);
		apb(0, PSR_OFF_CFG, 0);
		chk(r, 32'h44);
		sleep_pin <= 1'b0;
		settle();
		chk(sleep_en, 1);
		apb(1, PSR_OFF_CFG, 32'h0);
		sleep_pin <= 1'b1;
		settle();
		chk(sleep_en, 0);
		chk(pause_adv, 32'h0);
		apb(0, 8'h04, 0);
		chk(e, 1);
		$display("test straps done");
		// Pin reset with fiber strapped
		@(posedge pclk);
		fiber <= 1'b1;
		hw_reset_n <= 1'b0;
		repeat (3) @(posedge pclk);
		hw_reset_n <= 1'b1;
		wait_idle();
		chk(n >= RST && n <= RST + 3, 1);
		chk(media_fiber, 1);
		@(posedge pclk);
		sig <= 1'b1;
		settle();
		chk(fiber_signal_detect, 1);
		@(posedge pclk);
		sig <= 1'b0;
		settle();
		chk(fiber_signal_detect, 0);
		$display("test fiber done");
		// Software reset, bit clears itself
		apb(1, PSR_OFF_CTRL, 32'h8000);
		@(posedge pclk);
		#1;
		chk(reset_busy, 1);
		wait_idle();
		chk(n >= RST - 3 && n <= RST + 2, 1);
		apb(0, PSR_OFF_CTRL, 0);
		chk(r & 32'h8000, 0);
		$display("test soft reset done");
		// Management disabled, pins govern live
		@(posedge pclk);
		mgmt_disable_strap <= 1'b1;
		sleep_pin <= 1'b0;
		hw_reset_n <= 1'b0;
		repeat (3) @(posedge pclk);
		hw_reset_n <= 1'b1;
		wait_idle();
		apb(0, PSR_OFF_STAT, 0);
		chk(r, 0);
		apb(1, PSR_OFF_CFG, 32'h40);
		settle();
		chk(sleep_en, 0);
		chk(media_fiber, 32'h1);
		@(posedge pclk);
		sleep_pin <= 1'b1;
		settle();
		chk(sleep_en, 1);
		$display("test unmanaged done");
		results();
	end
endmodule // phy_strap_reset_config_tb
